/* sppi_top.sv */
`timescale 1ns/10ps
`include "sppi_params.svh"
module sppi_top
  import sppi_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       sel_n_in,
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic       miso_in,
  output logic            sclk_out,
  output logic            sclk_oe,
  output logic            mosi_out,
  output logic            mosi_oe,
  output logic            miso_out,
  output logic            miso_oe,
  output logic            alt_pins,
  input  wire logic       adc_req,
  output logic            irq,
  output logic      [1:0] irq_prio
);
  sppi_if rif();
  sppi_rate u_rate (
    .ref_clk (ref_clk),
    .reset   (reset),
    .rg      (rif)
  );

  // Two-flop synchronisers for pin inputs
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
    end else begin
      s1_q <= {sel_n_in, sclk_in, mosi_in, miso_in};
      s2_q <= s1_q;
    end
  end
  logic sel_n;
  logic sclk_s;
  logic mosi_s;
  logic miso_s;
  assign {sel_n, sclk_s, mosi_s, miso_s} = s2_q;

  logic [7:0] ctl_q, ctl_d, sta_q, sta_d, aux_q, aux_d;
  logic [7:0] aux2_q, aux2_d, ie_q, ie_d, iph_q, iph_d, ip_q, ip_d;
  logic [7:0] sh_q, sh_d, rbuf_q, rbuf_d, rdata_d;
  logic [2:0] bit_q, bit_d;
  logic       sclk_prev_q, sclk_prev_d;
  logic       lat_q, lat_d;
  sppi_state_t st_q, st_d;

  function automatic logic fbit(input logic [7:0] v, input logic lsb);
    fbit = lsb ? v[0] : v[7];
  endfunction
  function automatic logic [7:0] fshift(input logic [7:0] v, input logic lsb,
                                        input logic b);
    fshift = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  logic en, ign, role, pol, pha, lsbf;
  assign en   = ctl_q[`SPPI_B_EN];
  assign ign  = ctl_q[`SPPI_B_IGNORE];
  assign role = ctl_q[`SPPI_B_ROLE];
  assign pol  = ctl_q[`SPPI_B_POL];
  assign pha  = ctl_q[`SPPI_B_PHA];
  assign lsbf = ctl_q[`SPPI_B_ORDER];

  logic is_master, slave_sel, active;
  // Role and selection
  assign is_master = en && role;
  assign slave_sel = en && !role && (ign || !sel_n);
  assign active    = (st_q != SPPI_IDLE);
  assign rif.rate  = ctl_q[1:0];
  assign rif.run   = is_master && active;

  logic wr_data, sclk_rise, sclk_fall, lead_e, trail_e;
  assign wr_data   = wr && (addr == `SPPI_ADR_DATA);
  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  // Leading edge depends on polarity
  assign lead_e    = pol ? sclk_fall : sclk_rise;
  assign trail_e   = pol ? sclk_rise : sclk_fall;

  logic pin_d;
  always_comb begin
    ctl_d = ctl_q;
    sta_d = sta_q;
    aux_d = aux_q;
    aux2_d = aux2_q;
    ie_d = ie_q;
    iph_d = iph_q;
    ip_d = ip_q;
    sh_d = sh_q;
    rbuf_d = rbuf_q;
    bit_d = bit_q;
    st_d = st_q;
    lat_d = lat_q;
    sclk_prev_d = sclk_s;
    pin_d = is_master ? miso_s : mosi_s;
    if (wr) begin
      case (addr)
        `SPPI_ADR_CONTROL: ctl_d = wdata;
        `SPPI_ADR_STATUS: begin
          if (wdata[`SPPI_B_DONE]) sta_d[`SPPI_B_DONE] = 1'b0;
          if (wdata[`SPPI_B_COLL]) sta_d[`SPPI_B_COLL] = 1'b0;
        end
        `SPPI_ADR_AUX:  aux_d = wdata;
        `SPPI_ADR_AUX2: aux2_d = wdata;
        `SPPI_ADR_IE:   ie_d = wdata;
        `SPPI_ADR_IPH:  iph_d = wdata;
        `SPPI_ADR_IP:   ip_d = wdata;
        default: ;
      endcase
    end
    if (!en) begin
      st_d = SPPI_IDLE;
    end else if (role && !ign && sel_n == 1'b0 && !active) begin
      ctl_d[`SPPI_B_ROLE] = 1'b0;
      sta_d[`SPPI_B_DONE] = 1'b1;
    end else if (wr_data) begin
      if (active) begin
        sta_d[`SPPI_B_COLL] = 1'b1;
      end else begin
        sh_d = wdata;
        if (is_master) begin
          // Phase 1 holds idle level a half bit before lead
          st_d = pha ? SPPI_WAIT : SPPI_LEAD;
          bit_d = 3'h0;
        end
      end
    end
    if (en) begin
      case (st_q)
        SPPI_IDLE: begin
          // Slave begins on first leading edge while selected
          if (slave_sel && lead_e) begin
            bit_d = 3'h0;
            if (!pha) begin
              lat_d = pin_d;
              st_d = SPPI_TRAIL;
            end else begin
              st_d = SPPI_TRAIL;
            end
          end
        end
        SPPI_LEAD: begin
          if ((is_master && rif.tick) || (!is_master && slave_sel && lead_e)) begin
            st_d = SPPI_TRAIL;
            if (!pha) lat_d = pin_d;
            else if (bit_q != 3'h0 && !is_master) sh_d = fshift(sh_q, lsbf, lat_q);
          end
        end
        SPPI_TRAIL: begin
          if ((is_master && rif.tick) || (!is_master && slave_sel && trail_e)) begin
            // Exchange of bytes by shifting
            if (!pha) sh_d = fshift(sh_q, lsbf, lat_q);
            else if (is_master) sh_d = fshift(sh_q, lsbf, pin_d);
            else lat_d = pin_d;
            bit_d = bit_q + 3'h1;
            st_d = SPPI_LEAD;
            if (bit_q == 3'h7) begin
              st_d = SPPI_IDLE;
              sta_d[`SPPI_B_DONE] = 1'b1;
              if (!pha) rbuf_d = fshift(sh_q, lsbf, lat_q);
              else rbuf_d = fshift(sh_q, lsbf, pin_d);
              sh_d = rbuf_d;
            end
          end
        end
        SPPI_WAIT: begin
          if (!is_master) begin
            st_d = SPPI_IDLE;
          end else if (rif.tick) begin
            st_d = SPPI_LEAD;
          end
        end
        default: st_d = SPPI_IDLE;
      endcase
    end
    case (addr)
      `SPPI_ADR_CONTROL: rdata_d = ctl_q;
      `SPPI_ADR_STATUS:  rdata_d = {sta_q[7:6], 6'h00};
      `SPPI_ADR_DATA:    rdata_d = rbuf_q;
      `SPPI_ADR_AUX:     rdata_d = aux_q;
      `SPPI_ADR_AUX2:    rdata_d = aux2_q;
      `SPPI_ADR_IE:      rdata_d = ie_q;
      `SPPI_ADR_IPH:     rdata_d = iph_q;
      `SPPI_ADR_IP:      rdata_d = ip_q;
      default:           rdata_d = 8'h00;
    endcase
    if (!rd) rdata_d = 8'h00;
  end

  // Pin drive
  logic sclk_o_d, sclk_oe_d, mosi_d, mosi_oe_d, miso_d, miso_oe_d, irq_d;
  always_comb begin
    sclk_o_d  = pol ^ (pha ? (st_q == SPPI_LEAD) : (st_q == SPPI_TRAIL));
    sclk_oe_d = is_master && active;
    mosi_oe_d = is_master && active;
    miso_oe_d = slave_sel;
    mosi_d    = fbit(sh_q, lsbf);
    miso_d    = fbit(sh_q, lsbf);
    // Shared request gating
    irq_d = ie_q[`SPPI_B_GIE] && ie_q[`SPPI_B_SHARED] &&
            ((sta_q[`SPPI_B_DONE] && aux_q[`SPPI_B_PORTIE]) ||
             (adc_req && aux_q[`SPPI_B_ADCIE]));
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl_q <= `SPPI_CTL_RESET;
      sta_q <= 8'h00;
      aux_q <= 8'h00;
      aux2_q <= 8'h00;
      ie_q <= 8'h00;
      iph_q <= 8'h00;
      ip_q <= 8'h00;
      sh_q <= 8'h00;
      rbuf_q <= 8'h00;
      bit_q <= 3'h0;
      st_q <= SPPI_IDLE;
      lat_q <= 1'b0;
      sclk_prev_q <= 1'b1;
      rdata <= 8'h00;
      sclk_out <= 1'b0;
      sclk_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      alt_pins <= 1'b0;
      irq <= 1'b0;
      irq_prio <= 2'h0;
    end else begin
      ctl_q <= ctl_d;
      sta_q <= sta_d;
      aux_q <= aux_d;
      aux2_q <= aux2_d;
      ie_q <= ie_d;
      iph_q <= iph_d;
      ip_q <= ip_d;
      sh_q <= sh_d;
      rbuf_q <= rbuf_d;
      bit_q <= bit_d;
      st_q <= st_d;
      lat_q <= lat_d;
      sclk_prev_q <= sclk_prev_d;
      rdata <= rdata_d;
      sclk_out <= sclk_o_d;
      sclk_oe <= sclk_oe_d;
      mosi_out <= mosi_d;
      mosi_oe <= mosi_oe_d;
      miso_out <= miso_d;
      miso_oe <= miso_oe_d;
      alt_pins <= aux2_q[`SPPI_B_RELOC];
      irq <= irq_d;
      irq_prio <= {iph_q[`SPPI_B_PRIO], ip_q[`SPPI_B_PRIO]};
    end
  end
endmodule

/* sppi_params.svh */
// Function
// - Global enable off blocks every interrupt
// - Bit 5 shared enable gates port and converter
// - Port interrupt enable bit 3, default off
// - Priority from upper and lower priority bits
// - Disabled port releases pins, ignores select
// - Clock pin output as master, input slave
// - Select ignore: role bit alone picks role
// - Low select on idle master forces slave
// - Stays slave until role bit set again
// - Selected slave drives its data output
// - Unselected slave data output high impedance
// - Idle master floats data out and clock
// - Active master drives data and clock
// - Master data write starts one byte
// - First bit within one bit time
// - Bytes exchanged between master and slave
// - Eight bits set done flag, request
// - Write during transfer sets collision, dropped
// - Received byte kept in read buffer
// - Writing 1 clears collision flag
// - Relocate bit moves pins to alternate port
// - Clock divide 4, 16, 64, 128
// - Polarity sets idle level and lead edge
// - Phase picks drive and sample edges
// - Writing 1 clears done flag
`ifndef SPPI_PARAMS_SVH
`define SPPI_PARAMS_SVH
`define SPPI_ADR_STATUS   8'h84
`define SPPI_ADR_CONTROL  8'h85
`define SPPI_ADR_DATA     8'h86
`define SPPI_ADR_AUX      8'h8E
`define SPPI_ADR_AUX2     8'hA2
`define SPPI_ADR_IE       8'hA8
`define SPPI_ADR_IPH      8'hB7
`define SPPI_ADR_IP       8'hB8
`define SPPI_CTL_RESET    8'h04
`define SPPI_B_IGNORE     7
`define SPPI_B_EN         6
`define SPPI_B_ORDER      5
`define SPPI_B_ROLE       4
`define SPPI_B_POL        3
`define SPPI_B_PHA        2
`define SPPI_B_DONE       7
`define SPPI_B_COLL       6
`define SPPI_B_GIE        7
`define SPPI_B_SHARED     5
`define SPPI_B_PORTIE     3
`define SPPI_B_ADCIE      4
`define SPPI_B_RELOC      5
`define SPPI_B_PRIO       5
`endif

/* sppi_pkg.sv */
package sppi_pkg;
  typedef enum logic [1:0] {
    SPPI_IDLE = 2'b00,
    SPPI_LEAD = 2'b01,
    SPPI_TRAIL = 2'b10,
    SPPI_WAIT = 2'b11
  } sppi_state_t;
  typedef logic [7:0] sppi_byte_t;
endpackage

/* sppi_if.sv */
`timescale 1ns/10ps
interface sppi_if;
  logic [1:0] rate;
  logic       tick;
  logic       run;
  modport gen (input rate, input run, output tick);
  modport use_(output rate, output run, input tick);
endinterface

/* sppi_rate.sv */
`timescale 1ns/10ps
`include "sppi_params.svh"
module sppi_rate
  import sppi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  sppi_if.gen      rg
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [5:0] lim;
  logic       tick_q;
  logic       tick_d;
  // Half period in clocks: 2,8,32,64 (bit /4,/16,/64,/128)
  always_comb begin
    case (rg.rate)
      2'b00: lim = 6'h01;
      2'b01: lim = 6'h07;
      2'b10: lim = 6'h1F;
      default: lim = 6'h3F;
    endcase
    tick_d = 1'b0;
    cnt_d = cnt_q + 6'h01;
    if (!rg.run) begin
      cnt_d = 6'h00;
    end else if (cnt_q >= lim) begin
      cnt_d = 6'h00;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign rg.tick = tick_q;
endmodule

/* sppi_chk.sv */
`timescale 1ns/10ps
`include "sppi_params.svh"
module sppi_chk (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       sel_n_in,
  input wire logic       adc_req,
  input wire logic       sclk_out,
  input wire logic       sclk_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [7:0] ctl_q, ie_q, aux_q;
  logic [6:0] cnt_q, half;
  logic [4:0] nt_q;
  logic       prev_q, tgl, unsel, go;
  assign tgl   = sclk_oe && (sclk_out != prev_q);
  assign half  = ctl_q[1] ? (ctl_q[0] ? 7'h40 : 7'h20) : (ctl_q[0] ? 7'h08 : 7'h02);
  assign unsel = ctl_q[6] && !ctl_q[7] && !ctl_q[4] && sel_n_in;
  assign go    = wr && addr == `SPPI_ADR_DATA && ctl_q[7:6] == 2'h3 && ctl_q[4] && !sclk_oe;
  // Shadow of written registers, half-bit length and edge counts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl_q <= `SPPI_CTL_RESET;
      ie_q  <= 8'h00;
      aux_q <= 8'h00;
    end else if (wr && addr == `SPPI_ADR_CONTROL) begin
      ctl_q <= wdata;
    end else if (wr && addr == `SPPI_ADR_IE) begin
      ie_q <= wdata;
    end else if (wr && addr == `SPPI_ADR_AUX) begin
      aux_q <= wdata;
    end
    prev_q <= sclk_out;
    cnt_q  <= tgl ? 7'h00 : cnt_q + 7'h01;
    nt_q   <= sclk_oe ? nt_q + {4'h0, tgl} : 5'h00;
  end
  a_global_off: assert property ((!ie_q[7]) [*2] |=> !irq)
    else $error("irq with global enable off");
  a_shared_off: assert property ((!ie_q[5]) [*2] |=> !irq)
    else $error("irq with shared enable off");
  a_port_off: assert property ((!aux_q[3] && !aux_q[4]) [*2] |=> !irq)
    else $error("irq with source enables off");
  a_conv_irq: assert property ((adc_req && aux_q[4] && ie_q[5] && ie_q[7]) [*3] |-> irq)
    else $error("converter request not passed");
  a_off_float: assert property ((!ctl_q[6]) [*2] |=> !(sclk_oe || mosi_oe || miso_oe))
    else $error("pin driven while disabled");
  a_unsel_float: assert property (unsel [*4] |-> !miso_oe)
    else $error("unselected slave drives data");
  a_start_xfer: assert property (go |-> ##[1:3] (sclk_oe && mosi_oe))
    else $error("data write did not start byte");
  a_half_len: assert property (tgl && nt_q != 5'h00 |-> cnt_q == half - 7'h01)
    else $error("wrong half bit length");
  a_edge_count: assert property ($fell(sclk_oe) |-> nt_q == 5'h10)
    else $error("byte without sixteen clock edges");
  a_idle_level: assert property ($rose(sclk_oe) |-> sclk_out == ctl_q[3])
    else $error("clock starts off idle level");
  cover property (go);
  cover property ($fell(sclk_oe) && ctl_q[1:0] == 2'h3);
  cover property (irq);
endmodule
bind sppi_top sppi_chk i_sppi_chk (.ref_clk, .reset, .addr, .wdata, .wr, .sel_n_in,
  .adc_req, .sclk_out, .sclk_oe, .mosi_oe, .miso_oe, .irq);

/* sppi_slave_model.sv */
`timescale 1ns/10ps
module sppi_slave_model (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] rx
);
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
  end
  always @(negedge sel_n) sh = tx;
  // Lead edge drives, trail edge samples
  always @(posedge sclk) if (!sel_n) begin
    miso = lsb ? sh[0] : sh[7];
    sh = lsb ? sh >> 1 : sh << 1;
  end
  always @(negedge sclk) if (!sel_n) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
  // Released line shows inverse of last level
  always @(posedge sel_n) miso = ~miso;
endmodule

/* spi_port_with_irq_enables_tb_top.sv */
`timescale 1ns/10ps
`include "sppi_params.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module spi_port_with_irq_enables_tb_top import sppi_pkg::*;;
  typedef logic [23:0] sppi_row_t;
  sppi_row_t  rows [4] = '{24'hD5A55A, 24'hF6817E, 24'hD701C3, 24'hF4960F};
  logic       ref_clk, reset, wr, rd, sel_n_in, adc_req, s_sel_n, s_lsb, s_miso;
  logic       sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, alt_pins, irq;
  logic [1:0] irq_prio;
  sppi_byte_t addr, wdata, rdata, s_tx, s_rx, d;
  int         miscompares = 0;
  int         tests_run = 0;
  // Clock line pulled low, matching idle level
  sppi_top i_sppi_top (.ref_clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .sel_n_in,
    .sclk_in(sclk_oe ? sclk_out : 1'b0), .mosi_in(mosi_oe ? mosi_out : ~mosi_out),
    .miso_in(s_miso), .sclk_out, .sclk_oe, .mosi_out, .mosi_oe, .miso_out, .miso_oe,
    .alt_pins, .adc_req, .irq, .irq_prio);
  sppi_slave_model i_sppi_slave_model (.sclk(sclk_oe ? sclk_out : 1'b0), .mosi(mosi_out),
    .sel_n(s_sel_n), .lsb(s_lsb), .tx(s_tx), .miso(s_miso), .rx(s_rx));
  task automatic wreg(input sppi_byte_t a, input sppi_byte_t v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input sppi_byte_t a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic conclude;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wdone;
    for (int i = 0; i < 1000; i++) begin
      rreg(`SPPI_ADR_STATUS);
      if (d[7] === 1'b1) return;
    end
    miscompares++;
    conclude();
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    {reset, sel_n_in, s_sel_n} = 3'h7;
    {wr, rd, adc_req, s_lsb, addr, wdata, s_tx} = '0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    wreg(`SPPI_ADR_IE, 8'hA0);
    wreg(`SPPI_ADR_AUX, 8'h08);
    foreach (rows[k]) begin
      wreg(`SPPI_ADR_CONTROL, rows[k][23:16]);
      s_lsb <= rows[k][21];
      s_tx <= rows[k][7:0];
      s_sel_n <= 1'b0;
      wreg(`SPPI_ADR_DATA, rows[k][15:8]);
      wdone();
      repeat (2) @(posedge ref_clk);
      `CHK("irq", 1'b1, irq)
      rreg(`SPPI_ADR_DATA);
      `CHK("rx", rows[k][7:0], d)
      `CHK("slave rx", rows[k][15:8], s_rx)
      wreg(`SPPI_ADR_STATUS, 8'hC0);
      s_sel_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("irq clr", 1'b0, irq)
      $display("end of row %0d", k);
    end
    wreg(`SPPI_ADR_CONTROL, 8'hD5);
    s_lsb <= 1'b0;
    s_sel_n <= 1'b0;
    wreg(`SPPI_ADR_DATA, 8'h3C);
    wreg(`SPPI_ADR_DATA, 8'hFF);
    wdone();
    rreg(`SPPI_ADR_STATUS);
    `CHK("coll", 8'hC0, d & 8'hC0)
    `CHK("kept", 8'h3C, s_rx)
    wreg(`SPPI_ADR_IE, 8'h20);
    repeat (3) @(posedge ref_clk);
    `CHK("gie off", 1'b0, irq)
    wreg(`SPPI_ADR_IE, 8'hA0);
    repeat (3) @(posedge ref_clk);
    `CHK("gie on", 1'b1, irq)
    wreg(`SPPI_ADR_AUX, 8'h10);
    repeat (3) @(posedge ref_clk);
    `CHK("pie off", 1'b0, irq)
    adc_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK("conv", 1'b1, irq)
    adc_req <= 1'b0;
    wreg(`SPPI_ADR_STATUS, 8'h40);
    rreg(`SPPI_ADR_STATUS);
    `CHK("coll clr", 8'h80, d & 8'hC0)
    wreg(`SPPI_ADR_STATUS, 8'h80);
    s_sel_n <= 1'b1;
    $display("end of collision test");
    for (int p = 0; p < 4; p++) begin
      wreg(`SPPI_ADR_IPH, {2'h0, p[1], 5'h00});
      wreg(`SPPI_ADR_IP, {2'h0, p[0], 5'h00});
      repeat (2) @(posedge ref_clk);
      `CHK("prio", p[1:0], irq_prio)
    end
    wreg(`SPPI_ADR_AUX2, 8'h20);
    repeat (2) @(posedge ref_clk);
    `CHK("reloc", 1'b1, alt_pins)
    wreg(`SPPI_ADR_CONTROL, 8'h54);
    sel_n_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rreg(`SPPI_ADR_CONTROL);
    `CHK("role", 1'b0, d[4])
    `CHK("sel drive", 1'b1, miso_oe)
    wreg(`SPPI_ADR_DATA, 8'h96);
    repeat (2) @(posedge ref_clk);
    `CHK("slave msb", 1'b1, miso_out)
    rreg(`SPPI_ADR_STATUS);
    `CHK("mode chg", 1'b1, d[7])
    wreg(`SPPI_ADR_CONTROL, 8'h44);
    sel_n_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK("unsel", 1'b0, miso_oe)
    wreg(`SPPI_ADR_CONTROL, 8'h04);
    repeat (3) @(posedge ref_clk);
    `CHK("off", 3'h0, {sclk_oe, mosi_oe, miso_oe})
    $display("end of mode test");
    reset <= 1'b1;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rreg(`SPPI_ADR_CONTROL);
    `CHK("ctl rst", 8'h04, d)
    rreg(`SPPI_ADR_AUX);
    `CHK("pie rst", 1'b0, d[3])
    rreg(8'h10);
    `CHK("unmapped", 8'h00, d)
    $display("end of reset test");
    conclude();
  end
endmodule
